// ### dv/board_model.sv
// Board-side model: drives the macrocell pins and the clock pin.
// Assumes the bench changes requests right after mclk edges.
`timescale 1ns/1ps
module board_model
  import macro_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_req,
  input wire logic [NUM_CELLS-1:0] drv_en,
  input wire logic [NUM_CELLS-1:0] drv_val,
  input wire logic [NUM_CELLS-1:0] io_oe,
  output logic clk_pin,
  output logic [NUM_CELLS-1:0] io_in,
  output logic [NUM_CELLS-1:0] io_driven
);
  // ==========================================================
  // Pin drive
  // clock still in reset
  assign clk_pin = clk_req & ~rst;
  // Never fight the device; a released line floats to its pull-up level
  assign io_driven = drv_en & ~io_oe;
  assign io_in = (drv_val & io_driven) | ~io_driven;
endmodule : board_model

// ### dv/macro_assertions.sv
// Port-level assertions for the configurable macrocell array top.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ps
module macro_assertions
  import macro_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [NUM_IN-1:0] in_pin,
  input wire logic [NUM_IN-1:0] in_driven,
  input wire logic clk_pin,
  input wire logic clk_driven,
  input wire logic oe_n_pin,
  input wire logic oe_n_driven,
  input wire logic [NUM_CELLS-1:0] io_in,
  input wire logic [NUM_CELLS-1:0] io_driven,
  input wire logic [NUM_CELLS-1:0] io_out,
  input wire logic [NUM_CELLS-1:0] io_oe
);
  // ==========================================================
  // Helper state
  // Fuse is sticky to reset, so one status read showing it is enough
  logic secured;
  always_ff @(posedge mclk) begin
    if (rst) begin
      secured <= 1'b0;
    end else if (psel && penable && pready && !pwrite &&
        paddr == STATUS_OFS && prdata[0]) begin
      secured <= 1'b1;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_ready_wait: assert property (s_wait |=> pready)
    else $error("pready missing after access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_alone: assert property (pslverr |-> s_done)
    else $error("pslverr outside a completion");
  a_rdata_idle: assert property (!pready |-> prdata == '0)
    else $error("prdata not zero between transfers");
  a_unaligned_err: assert property (
      s_done ##0 paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access not refused");
  a_reset_quiet: assert property (disable iff (1'b0)
      rst |=> io_oe == '0 && io_out == '0 && !pready)
    else $error("pins or bus active after reset");
  a_sig_open: assert property (s_done ##0
      (paddr == SIG_LO_OFS || paddr == SIG_HI_OFS) |-> !pslverr)
    else $error("signature access refused");
  a_verify_shut: assert property (s_done ##0 (secured && !pwrite
      && paddr >= TERM_BASE && paddr <= TERM_LAST) |->
      pslverr && prdata == '0)
    else $error("term readback allowed while secured");
  a_preload_shut: assert property (s_done ##0 (secured && pwrite
      && paddr == PRELOAD_OFS) |-> pslverr)
    else $error("preload accepted while secured");
endmodule : macro_assertions

bind configurable_macrocell_array macro_assertions u_chk (.*);

// ### dv/testbench.sv
// Self-checking bench: APB programming of the array, pins observed.
// Assumes the board model supplies macrocell pins and the clock pin.
`timescale 1ns/1ps
module testbench
  import macro_pkg::*;
;
  // ==========================================================
  // Signals and instances
  logic mclk = 1'b0, rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, clk_pin, clk_req = 1'b0;
  logic [NUM_IN-1:0] in_pin = '0, in_driven = '1;
  logic clk_driven = 1'b1, oe_n_pin = 1'b0, oe_n_driven = 1'b1;
  logic [NUM_CELLS-1:0] drv_en = '0, drv_val = '0;
  logic [NUM_CELLS-1:0] io_in, io_driven, io_out, io_oe;
  int n_mismatch = 0, num_checks = 0;
  always #50 mclk = ~mclk;
  configurable_macrocell_array u_dut (.*);
  board_model u_board (.*);
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic xf(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] x, input logic xe);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    check({31'h0, pready}, 32'h1);
    if (!w) check(prdata, x);
    check({31'h0, pslverr}, {31'h0, xe});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : xf
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xf(1'b1, a, d, '0, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    xf(1'b0, a, '0, x, 1'b0);
  endtask : rd
  // One true column per term; the second word holds columns 39:32
  task automatic term(input int t, input int col);
    wr(TERM_BASE + 12'(8 * t), col < 32 ? 32'h1 << col : '0);
    wr(TERM_BASE + 12'(8 * t + 4), col < 32 ? '0 : 32'h1 << (col - 32));
  endtask : term
  task automatic setup(input mode_t m, input logic [31:0] cfg);
    wr(CTRL_OFS, 32'h1);
    wr(CTRL_OFS, {29'h0, m, 1'b1});
    wr(CELLCFG_OFS, cfg);
  endtask : setup
  task automatic pins(input logic [7:0] oe, input logic [7:0] out);
    repeat (4) @(posedge mclk);
    check({16'h0, io_oe, io_out & io_oe}, {16'h0, oe, out});
  endtask : pins
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    pins(8'h00, 8'h00);
    rd(CTRL_OFS, 32'h0);
    rd(CELLCFG_OFS, 32'h0000FFFF);
    rd(SIG_LO_OFS, 32'h0);
    xf(1'b0, 12'h01C, '0, '0, 1'b1);
    xf(1'b1, 12'h002, 32'h1, '0, 1'b1);
  endtask : t_reset
  task automatic t_simple;
    setup(MODE_SIMPLE, 32'h0000FFEF);
    term(16, 0);
    term(24, 1);
    wr(CTRL_OFS, {29'h0, MODE_SIMPLE, 1'b0});
    in_driven[0] <= 1'b0;
    pins(8'h1C, 8'h04);
    in_driven[0] <= 1'b1;
    pins(8'h1C, 8'h08);
  endtask : t_simple
  task automatic t_reg;
    // Cell 1 is comb I/O: its enable term alone must not reach the sum
    setup(MODE_REG, 32'h0000FFF4);
    term(0, 0);
    term(8, 0);
    wr(CTRL_OFS, {29'h0, MODE_REG, 1'b0});
    pins(8'h01, 8'h01);
    in_pin[0] <= 1'b1;
    pins(8'h03, 8'h01);
    clk_req <= 1'b1;
    pins(8'h03, 8'h00);
    in_pin[0] <= 1'b0;
    oe_n_pin <= 1'b1;
    pins(8'h00, 8'h00);
    rd(STATUS_OFS, 32'h00000100);
    clk_req <= 1'b0;
  endtask : t_reg
  task automatic t_cplx;
    setup(MODE_CPLX, 32'h0000EFE7);
    term(8, 0);
    term(9, 2);
    term(17, 26);
    term(49, 39);
    wr(CTRL_OFS, {29'h0, MODE_CPLX, 1'b0});
    in_pin[1:0] <= 2'b11;
    drv_en <= 8'h82;
    drv_val <= 8'h80;
    pins(8'h46, 8'h46);
    in_pin[0] <= 1'b0;
    pins(8'h44, 8'h40);
    drv_val <= 8'h82;
    pins(8'h44, 8'h44);
    wr(CTRL_OFS, 32'h4);
    rd(CTRL_OFS, 32'h2);
    drv_en <= 8'h00;
  endtask : t_cplx
  task automatic t_fuse;
    setup(MODE_REG, 32'h0000FFFF);
    wr(CTRL_OFS, 32'h7);
    rd(CTRL_OFS, 32'h1);
    wr(PRELOAD_OFS, 32'h000000A5);
    rd(STATUS_OFS, 32'h0000A508);
    wr(SIG_LO_OFS, 32'h12345678);
    wr(FUSE_OFS, 32'h1);
    rd(STATUS_OFS, 32'h0000A509);
    xf(1'b0, TERM_BASE, '0, '0, 1'b1);
    xf(1'b1, PRELOAD_OFS, 32'h5A, '0, 1'b1);
    rd(STATUS_OFS, 32'h0000A50F);
    wr(SIG_HI_OFS, 32'h9ABCDEF0);
    rd(SIG_LO_OFS, 32'h12345678);
    rd(SIG_HI_OFS, 32'h9ABCDEF0);
    wr(STATUS_OFS, 32'h6);
    rd(STATUS_OFS, 32'h0000A509);
  endtask : t_fuse
  // ==========================================================
  // Run control
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_simple;
    t_reg;
    t_cplx;
    t_fuse;
    conclude;
  end
  // Whole run is a few hundred cycles; this bound only cuts a hang
  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    conclude;
  end
endmodule : testbench

// ### logic/configurable_macrocell_array.sv
// Top of the configurable macrocell array with its APB register file.
// Assumes pins and APB are synchronous to mclk; the clock pin is sampled.
//
// Functional notes
// - 64-bit user signature always readable and writable, even when secured.
// - Secured device refuses product-term readback and register preload.
// - Eight macrocells, each registered, comb I/O, comb output or input.
// - Exactly one of three global modes: registered, complex, simple.
// - Registered cells clock on the clock pin, enable from enable pin.
// - Registered cells sum eight product terms in registered mode.
// - Comb cells in registered mode: seven sum terms, one enable term.
// - A cell set as input drives its pin only as a centre cell in simple mode.
// - Complex mode: six inner cells feed pin values into the array.
// - Complex mode: two outer cells are outputs without pin feedback.
// - Complex mode: seven sum terms and one enable term per cell.
// - Simple mode: eight sum terms, no product-term enable.
// - Simple mode: two centre cells are fixed combinatorial outputs.
// - Simple mode: other cells are inputs or outputs with pin feedback.
// - Undriven input and I/O pins present a high to the array.
// - Reset clears all cell registers, registered pins show high.
// - Unsecured device lets software preload each register high or low.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module configurable_macrocell_array
  import macro_pkg::*;
(
  input logic mclk,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input logic [NUM_IN-1:0] in_pin,
  input logic [NUM_IN-1:0] in_driven,
  input logic clk_pin,
  input logic clk_driven,
  input logic oe_n_pin,
  input logic oe_n_driven,
  input logic [NUM_CELLS-1:0] io_in,
  input logic [NUM_CELLS-1:0] io_driven,
  output logic [NUM_CELLS-1:0] io_out,
  output logic [NUM_CELLS-1:0] io_oe
);
  // ==========================================================
  // State
  mode_t mode;
  mode_t next_mode;
  logic prog_en;
  logic next_prog_en;
  logic [15:0] cell_kind;
  logic [15:0] next_cell_kind;
  logic [7:0] cell_pol;
  logic [7:0] next_cell_pol;
  logic fuse;
  logic next_fuse;
  logic verify_refused;
  logic next_verify_refused;
  logic preload_refused;
  logic next_preload_refused;
  logic [31:0] sig_lo;
  logic [31:0] next_sig_lo;
  logic [31:0] sig_hi;
  logic [31:0] next_sig_hi;
  logic [NUM_COL-1:0] term_mask [NUM_PT];
  logic [NUM_CELLS-1:0] q;
  logic [NUM_CELLS-1:0] next_q;
  logic clk_prev;
  logic next_pready;
  logic [31:0] next_prdata;
  logic next_pslverr;

  // ==========================================================
  // Address decode
  function automatic logic hit(logic [11:0] addr, logic [11:0] ofs);
    return addr == ofs;
  endfunction : hit

  function automatic logic in_term(logic [11:0] addr);
    return addr >= TERM_BASE && addr <= TERM_LAST && addr[1:0] == 2'h0;
  endfunction : in_term

  wire access = psel & penable;
  wire rd_phase = access & ~pready;
  wire commit = access & pready;
  wire wr = commit & pwrite;
  wire hit_ctrl = hit(paddr, CTRL_OFS);
  wire hit_cellcfg = hit(paddr, CELLCFG_OFS);
  wire hit_fuse = hit(paddr, FUSE_OFS);
  wire hit_status = hit(paddr, STATUS_OFS);
  wire hit_preload = hit(paddr, PRELOAD_OFS);
  wire hit_sig_lo = hit(paddr, SIG_LO_OFS);
  wire hit_sig_hi = hit(paddr, SIG_HI_OFS);
  wire hit_term = in_term(paddr);
  wire [11:0] term_off = paddr - TERM_BASE;
  wire [5:0] term_idx = term_off[8:3];
  wire term_upper = term_off[2];
  wire mapped = hit_ctrl | hit_cellcfg | hit_fuse | hit_status |
                hit_preload | hit_sig_lo | hit_sig_hi | hit_term;

  wire refuse_verify = hit_term & ~pwrite & fuse;
  wire refuse_preload = hit_preload & pwrite & fuse;

  // ==========================================================
  // Read data selection
  wire [NUM_COL-1:0] term_word = term_mask[term_idx];
  wire [31:0] term_rd = term_upper ? {24'h000000, term_word[39:32]} :
                                     term_word[31:0];
  wire [31:0] ctrl_word = {29'h00000000, mode, prog_en};
  wire [31:0] cellcfg_word = {8'h00, cell_pol, cell_kind};
  wire [31:0] status_word = {8'h00, io_oe, q, 4'h0, prog_en,
                             preload_refused, verify_refused, fuse};
  wire [31:0] term_vis = fuse ? 32'h00000000 : term_rd;
  wire [31:0] rd_val =
    hit_ctrl ? ctrl_word :
    hit_cellcfg ? cellcfg_word :
    hit_fuse ? {31'h00000000, fuse} :
    hit_status ? status_word :
    hit_sig_lo ? sig_lo :
    hit_sig_hi ? sig_hi :
    hit_term ? term_vis :
    32'h00000000;

  // ==========================================================
  // APB answer
  // One wait state keeps every answer signal a plain flop.
  assign next_pready = rd_phase;
  assign next_prdata = (rd_phase & ~pwrite) ? rd_val : 32'h00000000;
  assign next_pslverr = rd_phase &
                        (~mapped | refuse_verify | refuse_preload);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Configuration writes
  wire cfg_wr = wr & prog_en;
  wire mode_ok = pwdata[CTRL_MODE_LSB +: 2] != 2'h3;

  assign next_prog_en = (wr & hit_ctrl) ? pwdata[CTRL_PROG_BIT] : prog_en;
  assign next_mode = (cfg_wr & hit_ctrl & mode_ok) ?
                     mode_t'(pwdata[CTRL_MODE_LSB +: 2]) : mode;
  assign next_cell_kind = (cfg_wr & hit_cellcfg) ? pwdata[15:0] :
                          cell_kind;
  assign next_cell_pol = (cfg_wr & hit_cellcfg) ?
                         pwdata[CELL_POL_LSB +: 8] : cell_pol;
  // fuse acts from the next cycle on
  assign next_fuse = fuse | (cfg_wr & hit_fuse & pwdata[0]);
  assign next_sig_lo = (wr & hit_sig_lo) ? pwdata : sig_lo;
  assign next_sig_hi = (wr & hit_sig_hi) ? pwdata : sig_hi;

  // Refusal flags: a new refusal wins over a clear in the same cycle
  wire clr_status = wr & hit_status;
  assign next_verify_refused = (commit & refuse_verify) |
    (verify_refused & ~(clr_status & pwdata[STAT_VREF_BIT]));
  assign next_preload_refused = (commit & refuse_preload) |
    (preload_refused & ~(clr_status & pwdata[STAT_PREF_BIT]));

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode <= MODE_REG;
      prog_en <= 1'b0;
      cell_kind <= CELL_KIND_RST;
      cell_pol <= CELL_POL_RST;
      fuse <= 1'b0;
      verify_refused <= 1'b0;
      preload_refused <= 1'b0;
      sig_lo <= 32'h00000000;
      sig_hi <= 32'h00000000;
    end else begin
      mode <= next_mode;
      prog_en <= next_prog_en;
      cell_kind <= next_cell_kind;
      cell_pol <= next_cell_pol;
      fuse <= next_fuse;
      verify_refused <= next_verify_refused;
      preload_refused <= next_preload_refused;
      sig_lo <= next_sig_lo;
      sig_hi <= next_sig_hi;
    end
  end

  // ==========================================================
  // Product term plane storage
  wire term_wr = cfg_wr & hit_term;

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int t = 0; t < NUM_PT; t++) begin
        term_mask[t] <= '0;
      end
    end else if (term_wr & term_upper) begin
      term_mask[term_idx][39:32] <= pwdata[7:0];
    end else if (term_wr) begin
      term_mask[term_idx][31:0] <= pwdata;
    end
  end

  // ==========================================================
  // Pins as the array sees them
  // undriven pins read high
  wire [NUM_IN-1:0] in_eff = in_pin | ~in_driven;
  wire clk_eff = clk_pin | ~clk_driven;
  wire oe_n_eff = oe_n_pin | ~oe_n_driven;
  wire [NUM_CELLS-1:0] ext_io = io_in | ~io_driven;
  // A pin we drive reads back our own level
  wire [NUM_CELLS-1:0] io_eff = (io_oe & io_out) | (~io_oe & ext_io);
  // clock and enable pins leave the array in registered mode
  wire [1:0] ctl_sig = (mode == MODE_REG) ? 2'b00 : {oe_n_eff, clk_eff};

  // ==========================================================
  // Array and macrocells
  cell_cfg_if cfg ();
  logic [NUM_PT-1:0] pt;
  logic [NUM_CELLS-1:0] cell_d;
  logic [NUM_CELLS-1:0] cell_val;
  logic [NUM_CELLS-1:0] cell_en;
  logic [NUM_CELLS-1:0] cell_fb;
  logic [NUM_CELLS-1:0] reg_cell;
  wire [NUM_SIG-1:0] arr_sig = {cell_fb, ctl_sig, in_eff};

  assign cfg.mode = mode;
  assign cfg.pol = cell_pol;
  assign cfg.prog_en = prog_en;
  for (genvar g = 0; g < NUM_CELLS; g++) begin : g_kind
    assign cfg.kind[g] = cell_kind_t'(cell_kind[2*g +: 2]);
  end

  product_array u_array (
    .mask (term_mask),
    .sig (arr_sig),
    .pt (pt)
  );

  macrocell_logic u_cells (
    .cfg (cfg),
    .pt (pt),
    .q (q),
    .pin (io_eff),
    .oe_n_pin (oe_n_eff),
    .d (cell_d),
    .val (cell_val),
    .en (cell_en),
    .fb (cell_fb),
    .reg_cell (reg_cell)
  );

  // ==========================================================
  // Cell registers
  wire clk_rise = clk_eff & ~clk_prev;
  wire preload = wr & hit_preload & ~fuse;
  // capture on a clock-pin rise, registered cells only
  wire [NUM_CELLS-1:0] captured = (q & ~reg_cell) | (cell_d & reg_cell);

  assign next_q = preload ? pwdata[7:0] :
                  clk_rise ? captured : q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      clk_prev <= 1'b1;
    end else begin
      q <= next_q;
      clk_prev <= clk_eff;
    end
  end

  // ==========================================================
  // Pin drivers
  // Outputs lag the array by one mclk so the top drives from flops.
  always_ff @(posedge mclk) begin
    if (rst) begin
      io_out <= '0;
      io_oe <= '0;
    end else begin
      io_out <= cell_val;
      io_oe <= cell_en;
    end
  end
endmodule : configurable_macrocell_array

// ### logic/macrocell_logic.sv
// OR plane and output control of the eight macrocells.
// Assumes pin values already carry the pull-up and own drive.
`timescale 1ns/1ps
module macrocell_logic
  import macro_pkg::*;
(
  cell_cfg_if.dst cfg,
  input logic [NUM_PT-1:0] pt,
  input logic [NUM_CELLS-1:0] q,
  input logic [NUM_CELLS-1:0] pin,
  input logic oe_n_pin,
  output logic [NUM_CELLS-1:0] d,
  output logic [NUM_CELLS-1:0] val,
  output logic [NUM_CELLS-1:0] en,
  output logic [NUM_CELLS-1:0] fb,
  output logic [NUM_CELLS-1:0] reg_cell
);
  logic [NUM_CELLS-1:0] sum8;
  logic [NUM_CELLS-1:0] sum7;
  logic [NUM_CELLS-1:0] pt_oe;

  function automatic logic kind_en(cell_kind_t k, logic oe_term);
    if (k == CELL_INPUT) return 1'b0;
    if (k == CELL_COMB_OUT) return 1'b1;
    return oe_term;
  endfunction : kind_en

  for (genvar g = 0; g < NUM_CELLS; g++) begin : g_sum
    assign sum8[g] = |pt[g*PT_PER_CELL +: PT_PER_CELL];
    assign sum7[g] = |pt[g*PT_PER_CELL+1 +: PT_PER_CELL-1];
    assign pt_oe[g] = pt[g*PT_PER_CELL];
  end
  assign d = sum8;

  always_comb begin
    val = '0;
    en = '0;
    fb = '0;
    reg_cell = '0;
    for (int i = 0; i < NUM_CELLS; i++) begin
      case (cfg.mode)
        MODE_REG: begin
          if (cfg.kind[i] == CELL_REG) begin
            reg_cell[i] = 1'b1;
            val[i] = ~q[i];
            en[i] = ~oe_n_pin;
            fb[i] = q[i];
          end else begin
            val[i] = sum7[i] ^ cfg.pol[i];
            en[i] = kind_en(cfg.kind[i], pt_oe[i]);
            fb[i] = pin[i];
          end
        end
        MODE_CPLX: begin
          val[i] = sum7[i] ^ cfg.pol[i];
          en[i] = kind_en(cfg.kind[i], pt_oe[i]);
          fb[i] = (i == OUTER_LO || i == OUTER_HI) ? 1'b0 : pin[i];
        end
        MODE_SIMPLE: begin
          val[i] = sum8[i] ^ cfg.pol[i];
          if (i == CENTER_LO || i == CENTER_HI) begin
            en[i] = 1'b1;
          end else begin
            en[i] = (cfg.kind[i] != CELL_INPUT);
            fb[i] = pin[i];
          end
        end
        default: begin
          en[i] = 1'b0;
        end
      endcase
      if (cfg.prog_en) begin
        en[i] = 1'b0;
      end
    end
  end
endmodule : macrocell_logic

// ### logic/product_array.sv
// AND plane: 64 product terms over 20 signals and their inverses.
// Assumes masks are stable; an empty mask gives a disabled term.
`timescale 1ns/1ps
module product_array
  import macro_pkg::*;
(
  input logic [NUM_COL-1:0] mask [NUM_PT],
  input logic [NUM_SIG-1:0] sig,
  output logic [NUM_PT-1:0] pt
);
  logic [NUM_COL-1:0] col;
  for (genvar g = 0; g < NUM_SIG; g++) begin : g_col
    assign col[2*g] = sig[g];
    assign col[2*g+1] = ~sig[g];
  end
  // Unused terms read low, as in an erased plane
  for (genvar t = 0; t < NUM_PT; t++) begin : g_pt
    assign pt[t] = (|mask[t]) & ((col & mask[t]) == mask[t]);
  end
endmodule : product_array

// ### pkg/cell_cfg_if.sv
// Configuration carried from the register file to the macrocells.
// Assumes the driver holds these static outside programming.
`timescale 1ns/1ps
interface cell_cfg_if;
  import macro_pkg::*;
  mode_t mode;
  cell_kind_t kind [NUM_CELLS];
  logic [NUM_CELLS-1:0] pol;
  logic prog_en;
  modport src (output mode, kind, pol, prog_en);
  modport dst (input mode, kind, pol, prog_en);
endinterface : cell_cfg_if

// ### pkg/macro_pkg.sv
// Constants, types and register map of the macrocell array.
// Assumes a 12-bit APB byte address and a 32-bit data path.
package macro_pkg;
  // ==========================================================
  // Array geometry
  localparam int NUM_CELLS = 8;
  localparam int NUM_IN = 10;
  localparam int NUM_SIG = 20;
  localparam int NUM_COL = 40;
  localparam int NUM_PT = 64;
  localparam int PT_PER_CELL = 8;
  localparam int OUTER_LO = 0;
  localparam int OUTER_HI = 7;
  localparam int CENTER_LO = 3;
  localparam int CENTER_HI = 4;
  // ==========================================================
  // Register offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CELLCFG_OFS = 12'h004;
  localparam logic [11:0] FUSE_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00C;
  localparam logic [11:0] PRELOAD_OFS = 12'h010;
  localparam logic [11:0] SIG_LO_OFS = 12'h014;
  localparam logic [11:0] SIG_HI_OFS = 12'h018;
  localparam logic [11:0] TERM_BASE = 12'h100;
  localparam logic [11:0] TERM_LAST = 12'h2FC;
  // ==========================================================
  // Field positions
  localparam int CTRL_PROG_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CELL_POL_LSB = 16;
  localparam int STAT_VREF_BIT = 1;
  localparam int STAT_PREF_BIT = 2;
  // ==========================================================
  // Types and reset values
  typedef enum logic [1:0] {MODE_REG, MODE_CPLX, MODE_SIMPLE} mode_t;
  typedef enum logic [1:0] {
    CELL_REG, CELL_COMB_IO, CELL_COMB_OUT, CELL_INPUT
  } cell_kind_t;
  localparam logic [15:0] CELL_KIND_RST = 16'hFFFF;
  localparam logic [7:0] CELL_POL_RST = 8'h00;
endpackage : macro_pkg
